// ### mstat_pkg.sv
// constants of the mac statistics counter bank
package mstat_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_MAX_SIZE   = 8'h04;
  localparam logic [7:0]  OFS_LPI_TRANS  = 8'h08;
  localparam logic [7:0]  OFS_LPI_TIME   = 8'h0c;
  localparam logic [7:0]  OFS_CTR_BASE   = 8'h10;
  localparam logic [7:0]  OFS_CTR_LAST   = 8'h4c;
  // control register fields
  localparam int          CTRL_EEE_BIT   = 0;
  localparam int          CTRL_FORCE_BAD_CHECKSUM_BIT  = 1;
  localparam int          CTRL_FPF_BIT   = 2;
  localparam logic [2:0]  CTRL_RST       = 3'h0;
  localparam logic [13:0] MAX_SIZE_RST   = 14'h05ee;
  // receive size-bin thresholds in bytes
  localparam logic [13:0] LEN_64         = 14'h0040;
  localparam logic [13:0] LEN_127        = 14'h007f;
  localparam logic [13:0] LEN_255        = 14'h00ff;
  localparam logic [13:0] LEN_511        = 14'h01ff;
  localparam logic [13:0] LEN_1023       = 14'h03ff;
  localparam logic [13:0] LEN_1518       = 14'h05ee;
  // deferral margin and collision abort threshold
  localparam logic [15:0] DEFER_MARGIN   = 16'h0010;
  localparam logic [4:0]  EXCESS_COL     = 5'h10;
  localparam logic [4:0]  ONE_COL        = 5'h01;
  // microsecond tick from the core clock period
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          US_NS          = 1000;
  localparam int          CYC_PER_US     = US_NS / CLK_PERIOD_NS;
  localparam logic [4:0]  US_DIV_LAST    = 5'(CYC_PER_US - 1);
  // frame counter slots, read at OFS_CTR_BASE + 4 * index
  typedef enum logic [3:0] {
    CT_RX64, CT_RX127, CT_RX255, CT_RX511, CT_RX1023, CT_RX1518, CT_RXBIG,
    CT_TX_FCS, CT_TX_DEFER, CT_TX_CARRIER, CT_TX_BADBYTES, CT_TX_SINGLE,
    CT_TX_MULTI, CT_TX_EXCOL, CT_TX_LATE, CT_TX_UCBYTES
  } mstat_ctr_e;
  localparam int          NUM_CTR        = 16;
endpackage : mstat_pkg

// ### mstat_link_if.sv
// signals between the counter bank top and its helpers
`timescale 1ns/1ps
`default_nettype none
interface mstat_link_if;
  logic        eee_en;
  logic        phy_lpi;
  logic [31:0] lpi_trans;
  logic [31:0] lpi_time;
  logic        defer;
  logic        byte_tick;
  logic        collision;
  logic        frame_done;
  logic [13:0] max_size;
  logic        excess;
  modport lpi_mp (input eee_en, phy_lpi, output lpi_trans, lpi_time);
  modport dfr_mp (input defer, byte_tick, collision, frame_done, max_size, output excess);
  modport top_mp (output eee_en, phy_lpi, defer, byte_tick, collision, frame_done,
                  max_size, input lpi_trans, lpi_time, excess);
endinterface : mstat_link_if
`default_nettype wire

// ### mstat_lpi.sv
// receive low-power-idle transition and time counters
`timescale 1ns/1ps
`default_nettype none
module mstat_lpi (
  input  wire logic          core_clk_i,
  input  wire logic          resetn_i,
  mstat_link_if.lpi_mp       lnk
);
  logic        lpi_prev_r;
  logic [4:0]  us_div_r;
  logic [31:0] trans_r;
  logic [31:0] time_r;

  // previous lpi level, forgotten while eee is off
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) lpi_prev_r <= 1'b0;
    else lpi_prev_r <= lnk.eee_en & lnk.phy_lpi;
  end

  // count rising edges of the phy indication
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) trans_r <= 32'h0000_0000;
    else if (!lnk.eee_en) trans_r <= 32'h0000_0000;
    else if (lnk.phy_lpi && !lpi_prev_r) trans_r <= trans_r + 32'h0000_0001;
  end

  // microseconds of lpi; no power-state gating
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      us_div_r <= 5'h00;
      time_r   <= 32'h0000_0000;
    end else if (!lnk.eee_en) begin
      us_div_r <= 5'h00;
      time_r   <= 32'h0000_0000;
    end else if (lnk.phy_lpi) begin
      if (us_div_r == mstat_pkg::US_DIV_LAST) begin
        us_div_r <= 5'h00;
        time_r   <= time_r + 32'h0000_0001;
      end else us_div_r <= us_div_r + 5'h01;
    end
  end

  assign lnk.lpi_trans = trans_r;
  assign lnk.lpi_time  = time_r;
endmodule : mstat_lpi
`default_nettype wire

// ### mstat_defer.sv
// per-attempt deferral timer with excess-deferral flag
`timescale 1ns/1ps
`default_nettype none
module mstat_defer (
  input  wire logic          core_clk_i,
  input  wire logic          resetn_i,
  mstat_link_if.dfr_mp       lnk
);
  logic [15:0] limit;
  logic [15:0] timer_r;
  logic        excess_r;

  // two max frame times plus the double-tag margin, in byte times
  assign limit = {1'b0, lnk.max_size, 1'b0} + mstat_pkg::DEFER_MARGIN;

  // byte-time timer, restarted when deferral ends or on collision
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) timer_r <= 16'h0000;
    else if (!lnk.defer || lnk.collision) timer_r <= 16'h0000;
    else if (lnk.byte_tick && timer_r != 16'hffff) timer_r <= timer_r + 16'h0001;
  end

  // sticky until frame end; a new excess in the end cycle wins over the clear
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) excess_r <= 1'b0;
    else if (lnk.defer && timer_r > limit) excess_r <= 1'b1;
    else if (lnk.frame_done) excess_r <= 1'b0;
  end

  assign lnk.excess = excess_r;
endmodule : mstat_defer
`default_nettype wire

// ### mstat_top.sv
// ethernet mac statistics counter bank
//
// Behaviour
// - count good rx frames of exactly 64 bytes, 20 bits
// - count good rx frames of 65 to 127 bytes, 20 bits
// - count good rx frames of 128 to 255 bytes, 20 bits
// - count good rx frames of 256 to 511 bytes, 20 bits
// - count good rx frames of 512 to 1023 bytes, 20 bits
// - count good rx frames of 1024 to 1518 bytes, 20 bits
// - count good rx frames longer than 1518 bytes, 20 bits
// - size bins skip address-filtered and fifo-overflow frames
// - 64-byte bin also skips pause frames filtered by forward_pause_filter
// - 32-bit count of receive lpi indication rising edges
// - 32-bit total of receive lpi time in microseconds
// - both lpi counters cleared and held while energy enable is low
// - lpi counters keep running in suspend zero, three and normal states
// - 20-bit count of frames sent with bad fcs, forced ones included
// - 20-bit count of frames deferred beyond two max frames plus 16 bytes
// - deferral timer restarts from zero after collision and back-off
// - 20-bit count of frames with carrier absent or lost
// - 32-bit total of bytes sent in errored transmissions
// - 20-bit counts of successes after one and after several collisions
// - abort frame on 16th collision and count such aborts, 20 bits
// - 20-bit count of frames aborted by late collision
// - 32-bit total of bytes in error-free unicast transmitted frames
// - unicast byte total excludes flow control and collision-cut attempts
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mstat_top (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // receive frame status, one pulse per frame end
  input  wire logic        rx_done_i,
  input  wire logic [13:0] rx_len_i,
  input  wire logic        rx_err_i,
  input  wire logic        rx_filt_fail_i,
  input  wire logic        rx_fifo_ovf_i,
  input  wire logic        rx_pause_i,
  // receive lpi indication from the phy
  input  wire logic        phy_rx_lpi_i,
  // transmit activity and frame status
  input  wire logic        tx_defer_i,
  input  wire logic        tx_byte_tick_i,
  input  wire logic        tx_collision_i,
  input  wire logic        tx_done_i,
  input  wire logic [13:0] tx_len_i,
  input  wire logic        tx_ok_i,
  input  wire logic        tx_fcs_bad_i,
  input  wire logic        tx_carrier_err_i,
  input  wire logic        tx_late_col_i,
  input  wire logic        tx_unicast_i,
  input  wire logic        tx_pause_i,
  // controls toward the mac datapath
  output logic             tx_abort_o,
  output logic             force_bad_checksum_o,
  output logic             energy_efficient_enable_o,
  output logic             forward_pause_filter_o
);

  mstat_link_if lnk ();

  logic [2:0]  mac_control_reg_r;
  logic [13:0] max_size_r;
  logic        waitreq_r;
  logic [31:0] readdata_r;
  logic [31:0] ctr_r [mstat_pkg::NUM_CTR];
  logic [4:0]  col_cnt_r;
  logic        abort_r;
  logic        rx_take;
  logic        rx_bin_ok;
  logic [3:0]  rx_bin;
  logic        tx_excol;
  logic        req;
  logic        accept;
  logic [31:0] rd_nxt;
  logic [15:0] inc_mask;
  logic [31:0] tx_bad_add;
  logic [31:0] tx_uc_add;

  // 20-bit wrapping increment
  function automatic logic [31:0] inc20(input logic [31:0] v);
    return {12'h000, 20'(v[19:0] + 20'h0_0001)};
  endfunction : inc20

  // size bin index of a received length
  function automatic logic [3:0] bin_of(input logic [13:0] len);
    logic [3:0] b;
    b = 4'(mstat_pkg::CT_RXBIG);
    if (len <= mstat_pkg::LEN_1518) b = 4'(mstat_pkg::CT_RX1518);
    if (len <= mstat_pkg::LEN_1023) b = 4'(mstat_pkg::CT_RX1023);
    if (len <= mstat_pkg::LEN_511) b = 4'(mstat_pkg::CT_RX511);
    if (len <= mstat_pkg::LEN_255) b = 4'(mstat_pkg::CT_RX255);
    if (len <= mstat_pkg::LEN_127) b = 4'(mstat_pkg::CT_RX127);
    return b;
  endfunction : bin_of

  // address inside the frame counter window
  function automatic logic in_ctr_win(input logic [7:0] a);
    return (a >= mstat_pkg::OFS_CTR_BASE) && (a <= mstat_pkg::OFS_CTR_LAST);
  endfunction : in_ctr_win

  // helpers, bound to the shared link
  mstat_lpi u_lpi (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .lnk        (lnk.lpi_mp)
  );

  mstat_defer u_defer (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .lnk        (lnk.dfr_mp)
  );

  // drive the link from registers and pins
  assign lnk.eee_en     = mac_control_reg_r[mstat_pkg::CTRL_EEE_BIT];
  assign lnk.phy_lpi    = phy_rx_lpi_i;
  assign lnk.defer      = tx_defer_i;
  assign lnk.byte_tick  = tx_byte_tick_i;
  assign lnk.collision  = tx_collision_i;
  assign lnk.frame_done = tx_done_i;
  assign lnk.max_size   = max_size_r;

  // request accepted on the edge where waitrequest is low
  assign req    = avs_read_i | avs_write_i;
  assign accept = req & ~waitreq_r;

  // one wait cycle per access, then one cycle low
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) waitreq_r <= 1'b1;
    else if (req && waitreq_r) waitreq_r <= 1'b0;
    else waitreq_r <= 1'b1;
  end

  // read mux; unmapped words read as zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (avs_address_i == mstat_pkg::OFS_CTRL) rd_nxt = {29'h0000_0000, mac_control_reg_r};
    else if (avs_address_i == mstat_pkg::OFS_MAX_SIZE) rd_nxt = {18'h0_0000, max_size_r};
    else if (avs_address_i == mstat_pkg::OFS_LPI_TRANS) rd_nxt = lnk.lpi_trans;
    else if (avs_address_i == mstat_pkg::OFS_LPI_TIME) rd_nxt = lnk.lpi_time;
    else if (in_ctr_win(avs_address_i) && avs_address_i[1:0] == 2'h0) begin
      rd_nxt = ctr_r[4'((avs_address_i - mstat_pkg::OFS_CTR_BASE) >> 2)];
    end
  end

  // read data taken in the wait cycle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) readdata_r <= 32'h0000_0000;
    else if (avs_read_i && waitreq_r) readdata_r <= rd_nxt;
  end

  // control register write
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) mac_control_reg_r <= mstat_pkg::CTRL_RST;
    else if (accept && avs_write_i && avs_address_i == mstat_pkg::OFS_CTRL &&
             avs_byteenable_i[0]) mac_control_reg_r <= avs_writedata_i[2:0];
  end

  // maximum frame size, low two byte lanes
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) max_size_r <= mstat_pkg::MAX_SIZE_RST;
    else if (accept && avs_write_i && avs_address_i == mstat_pkg::OFS_MAX_SIZE) begin
      if (avs_byteenable_i[0]) max_size_r[7:0] <= avs_writedata_i[7:0];
      if (avs_byteenable_i[1]) max_size_r[13:8] <= avs_writedata_i[13:8];
    end
  end

  // receive bin from the final frame status
  assign rx_take   = rx_done_i & ~rx_err_i & ~rx_filt_fail_i & ~rx_fifo_ovf_i;
  assign rx_bin    = bin_of(rx_len_i);
  assign rx_bin_ok = (rx_len_i == mstat_pkg::LEN_64) ?
                     ~(rx_pause_i & ~mac_control_reg_r[mstat_pkg::CTRL_FPF_BIT]) :
                     (rx_len_i > mstat_pkg::LEN_64);

  // excessive collision seen on this frame
  assign tx_excol = (col_cnt_r >= mstat_pkg::EXCESS_COL);

  // per-frame increment mask, frame end pulses only
  always_comb begin
    inc_mask = 16'h0000;
    if (rx_take && rx_bin_ok) begin
      if (rx_len_i == mstat_pkg::LEN_64) inc_mask[mstat_pkg::CT_RX64] = 1'b1;
      else inc_mask[rx_bin] = 1'b1;
    end
    if (tx_done_i) begin
      inc_mask[mstat_pkg::CT_TX_FCS] = tx_fcs_bad_i |
                                       mac_control_reg_r[mstat_pkg::CTRL_FORCE_BAD_CHECKSUM_BIT];
      inc_mask[mstat_pkg::CT_TX_DEFER]   = lnk.excess;
      inc_mask[mstat_pkg::CT_TX_CARRIER] = tx_carrier_err_i;
      inc_mask[mstat_pkg::CT_TX_SINGLE]  = tx_ok_i && col_cnt_r == mstat_pkg::ONE_COL;
      inc_mask[mstat_pkg::CT_TX_MULTI]   = tx_ok_i && col_cnt_r > mstat_pkg::ONE_COL;
      inc_mask[mstat_pkg::CT_TX_EXCOL]   = tx_excol;
      inc_mask[mstat_pkg::CT_TX_LATE]    = tx_late_col_i;
    end
  end

  // byte totals from the frame end status
  assign tx_bad_add = (tx_done_i && !tx_ok_i) ? {18'h0_0000, tx_len_i} : 32'h0000_0000;
  assign tx_uc_add  = (tx_done_i && tx_ok_i && tx_unicast_i && !tx_pause_i) ?
                      {18'h0_0000, tx_len_i} : 32'h0000_0000;

  // frame counter bank; wraps, cleared only by reset
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < mstat_pkg::NUM_CTR; i++) ctr_r[i] <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < mstat_pkg::NUM_CTR; i++) if (inc_mask[i]) ctr_r[i] <= inc20(ctr_r[i]);
      ctr_r[mstat_pkg::CT_TX_BADBYTES] <= ctr_r[mstat_pkg::CT_TX_BADBYTES] + tx_bad_add;
      ctr_r[mstat_pkg::CT_TX_UCBYTES]  <= ctr_r[mstat_pkg::CT_TX_UCBYTES] + tx_uc_add;
    end
  end

  // collisions of the current frame
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) col_cnt_r <= 5'h00;
    else if (tx_done_i) col_cnt_r <= 5'h00;
    else if (tx_collision_i && !tx_excol) col_cnt_r <= col_cnt_r + 5'h01;
  end

  // one-cycle abort request on the sixteenth collision
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) abort_r <= 1'b0;
    else abort_r <= tx_collision_i && !tx_done_i &&
                    col_cnt_r == mstat_pkg::EXCESS_COL - mstat_pkg::ONE_COL;
  end

  // outputs, all from flip-flops
  assign avs_readdata_o            = readdata_r;
  assign avs_waitrequest_o         = waitreq_r;
  assign tx_abort_o                = abort_r;
  assign force_bad_checksum_o      = mac_control_reg_r[mstat_pkg::CTRL_FORCE_BAD_CHECKSUM_BIT];
  assign energy_efficient_enable_o = mac_control_reg_r[mstat_pkg::CTRL_EEE_BIT];
  assign forward_pause_filter_o    = mac_control_reg_r[mstat_pkg::CTRL_FPF_BIT];

endmodule : mstat_top
`default_nettype wire

// ### mstat_top_checker.sv
// concurrent checks on the statistics counter bank ports
`timescale 1ns/1ps
`default_nettype none
module mstat_top_checker (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_readdata_o,
  input  wire logic        avs_waitrequest_o,
  input  wire logic        tx_collision_i,
  input  wire logic        tx_done_i,
  input  wire logic        tx_abort_o,
  input  wire logic        force_bad_checksum_o,
  input  wire logic        energy_efficient_enable_o,
  input  wire logic        forward_pause_filter_o
);
  logic [4:0] col_cnt_r;
  logic       ctrl_wr;
  logic       rd_ack;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // accepted accesses
  assign ctrl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == mstat_pkg::OFS_CTRL
                   && avs_byteenable_i[0];
  assign rd_ack = avs_read_i && !avs_waitrequest_o;
  // collisions of the current attempt
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) col_cnt_r <= 5'h00;
    else if (tx_done_i) col_cnt_r <= 5'h00;
    else if (tx_collision_i) col_cnt_r <= col_cnt_r + 5'h01;
  end
  sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_ack; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  sequence s_col16; tx_collision_i && !tx_done_i && col_cnt_r == 5'h0f; endsequence
  a_wait_once: assert property (s_req |=> s_ack) else $error("slave answer not one cycle");
  a_idle_wait: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("waitrequest low without request");
  a_unmapped_zero: assert property (rd_ack && (avs_address_i > mstat_pkg::OFS_CTR_LAST
    || avs_address_i[1:0] != 2'b00) |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_bin_width: assert property (rd_ack && avs_address_i >= mstat_pkg::OFS_CTR_BASE
    && avs_address_i < 8'h4c && avs_address_i != 8'h38 |-> avs_readdata_o[31:20] == 12'h000)
    else $error("narrow counter upper bits set");
  a_lpi_cleared: assert property (rd_ack && avs_address_i[7:3] == 5'h01
    && $past(!energy_efficient_enable_o) && $past(!energy_efficient_enable_o, 2)
    |-> avs_readdata_o == 32'h0000_0000) else $error("lpi counter not held at zero");
  a_eee_follow: assert property (ctrl_wr |=> energy_efficient_enable_o
    == $past(avs_writedata_i[0])) else $error("enable bit not taken");
  a_ctrl_follow: assert property (ctrl_wr |=> {forward_pause_filter_o,
    force_bad_checksum_o} == $past(avs_writedata_i[2:1])) else $error("control bits not taken");
  a_ctrl_hold: assert property (!ctrl_wr |=> $stable({forward_pause_filter_o,
    force_bad_checksum_o, energy_efficient_enable_o})) else $error("control bits moved");
  a_abort_16th: assert property (s_col16 |=> tx_abort_o ##1 !tx_abort_o)
    else $error("abort pulse missing");
  a_abort_cause: assert property (tx_abort_o |-> $past(tx_collision_i)
    && $past(col_cnt_r) == 5'h0f) else $error("abort without 16th collision");
endmodule : mstat_top_checker
bind mstat_top mstat_top_checker chk_u (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .tx_collision_i(tx_collision_i),
  .tx_done_i(tx_done_i), .tx_abort_o(tx_abort_o), .force_bad_checksum_o(force_bad_checksum_o),
  .energy_efficient_enable_o(energy_efficient_enable_o),
  .forward_pause_filter_o(forward_pause_filter_o));
`default_nettype wire

// ### mstat_mac_model.sv
// mac datapath and phy model feeding frame and lpi events
`timescale 1ns/1ps
`default_nettype none
module mstat_mac_model (
  input  wire logic        core_clk_i,
  output logic             rx_done_o,
  output logic [13:0]      rx_len_o,
  output logic [3:0]       rx_stat_o,
  output logic             phy_rx_lpi_o,
  output logic             tx_defer_o,
  output logic             tx_byte_tick_o,
  output logic             tx_collision_o,
  output logic             tx_done_o,
  output logic [13:0]      tx_len_o,
  output logic [5:0]       tx_stat_o
);
  // quiet lines at time zero
  initial begin
    {rx_done_o, rx_len_o, rx_stat_o, phy_rx_lpi_o} = '0;
    {tx_defer_o, tx_byte_tick_o, tx_collision_o, tx_done_o, tx_len_o, tx_stat_o} = '0;
  end
  // receive frame end; status scrambled afterwards
  task automatic rx_frame(input logic [13:0] len, input logic [3:0] st);
    @(posedge core_clk_i);
    rx_done_o <= 1'b1;
    rx_len_o <= len;
    rx_stat_o <= st;
    @(posedge core_clk_i);
    rx_done_o <= 1'b0;
    rx_len_o <= ~len;
    rx_stat_o <= ~st;
  endtask : rx_frame
  // deferral lasting n byte times
  task automatic defer(input int n);
    if (n > 0) begin
      @(posedge core_clk_i);
      tx_defer_o <= 1'b1;
      repeat (n) begin
        @(posedge core_clk_i);
        tx_byte_tick_o <= 1'b1;
        @(posedge core_clk_i);
        tx_byte_tick_o <= 1'b0;
      end
      @(posedge core_clk_i);
      tx_defer_o <= 1'b0;
    end
  endtask : defer
  // transmit attempt: defer, collide, defer, end
  task automatic tx_frame(input logic [13:0] len, input logic [5:0] st, input int nc,
                          input int d1, input int d2);
    defer(d1);
    repeat (nc) begin
      @(posedge core_clk_i);
      tx_collision_o <= 1'b1;
      @(posedge core_clk_i);
      tx_collision_o <= 1'b0;
    end
    defer(d2);
    @(posedge core_clk_i);
    tx_done_o <= 1'b1;
    tx_len_o <= len;
    tx_stat_o <= st;
    @(posedge core_clk_i);
    tx_done_o <= 1'b0;
    tx_len_o <= ~len;
    tx_stat_o <= ~st;
  endtask : tx_frame
  // receive lpi held for n cycles
  task automatic lpi(input int n);
    @(posedge core_clk_i);
    phy_rx_lpi_o <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    phy_rx_lpi_o <= 1'b0;
  endtask : lpi
endmodule : mstat_mac_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the statistics counter bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [13:0] len; logic [3:0] st; logic fwd; logic [3:0] bin;} mstat_row_s;
  logic        core_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [7:0]  avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o, rd;
  logic        avs_waitrequest_o, tx_abort_o, fbc_o, eee_o, fwd_o;
  logic        rx_done, lpi, tx_defer, tx_tick, tx_col, tx_done;
  logic [3:0]  rx_st;
  logic [5:0]  tx_st;
  logic [13:0] rx_len, tx_len;
  logic [31:0] exp_c [16] = '{default: 32'h0000_0000};
  int          err_total = 0, tests_run = 0, abort_cnt = 0, lim;
  // len, {err, filter fail, overflow, pause}, forward pause, bin (7 none)
  mstat_row_s rows [19] = '{
    '{14'h0040, 4'h0, 1'b0, 4'h0}, '{14'h0041, 4'h0, 1'b0, 4'h1}, '{14'h007f, 4'h0, 1'b0, 4'h1},
    '{14'h0080, 4'h0, 1'b0, 4'h2}, '{14'h00ff, 4'h0, 1'b0, 4'h2}, '{14'h0100, 4'h0, 1'b0, 4'h3},
    '{14'h01ff, 4'h0, 1'b0, 4'h3}, '{14'h0200, 4'h0, 1'b0, 4'h4}, '{14'h03ff, 4'h0, 1'b0, 4'h4},
    '{14'h0400, 4'h0, 1'b0, 4'h5}, '{14'h05ee, 4'h0, 1'b0, 4'h5}, '{14'h05ef, 4'h0, 1'b0, 4'h6},
    '{14'h003f, 4'h0, 1'b0, 4'h7}, '{14'h0040, 4'h8, 1'b0, 4'h7}, '{14'h0064, 4'h4, 1'b0, 4'h7},
    '{14'h012c, 4'h2, 1'b0, 4'h7}, '{14'h0040, 4'h1, 1'b0, 4'h7}, '{14'h0040, 4'h1, 1'b1, 4'h0},
    '{14'h0064, 4'h1, 1'b0, 4'h1}};
  mstat_top dut_u (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_done_i(rx_done), .rx_len_i(rx_len),
    .rx_err_i(rx_st[3]), .rx_filt_fail_i(rx_st[2]), .rx_fifo_ovf_i(rx_st[1]),
    .rx_pause_i(rx_st[0]), .phy_rx_lpi_i(lpi), .tx_defer_i(tx_defer), .tx_byte_tick_i(tx_tick),
    .tx_collision_i(tx_col), .tx_done_i(tx_done), .tx_len_i(tx_len), .tx_ok_i(tx_st[5]),
    .tx_fcs_bad_i(tx_st[4]), .tx_carrier_err_i(tx_st[3]), .tx_late_col_i(tx_st[2]),
    .tx_unicast_i(tx_st[1]), .tx_pause_i(tx_st[0]), .tx_abort_o(tx_abort_o),
    .force_bad_checksum_o(fbc_o), .energy_efficient_enable_o(eee_o),
    .forward_pause_filter_o(fwd_o));
  mstat_mac_model phy_u (.core_clk_i(core_clk_i), .rx_done_o(rx_done), .rx_len_o(rx_len),
    .rx_stat_o(rx_st), .phy_rx_lpi_o(lpi), .tx_defer_o(tx_defer), .tx_byte_tick_o(tx_tick),
    .tx_collision_o(tx_col), .tx_done_o(tx_done), .tx_len_o(tx_len), .tx_stat_o(tx_st));
  // 20 MHz core clock
  always #25 core_clk_i = ~core_clk_i;
  // count abort pulses
  always @(posedge core_clk_i) begin
    if (tx_abort_o === 1'b1) abort_cnt++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdc
  task automatic cmp_ctr(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      rdc(8'(mstat_pkg::OFS_CTR_BASE + 4 * i), exp_c[i], $sformatf("ctr%0d", i));
    end
  endtask : cmp_ctr
  task automatic do_reset;
    resetn_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
  endtask : do_reset
  // transmit attempt with expected counter updates
  task automatic tx_do(input logic [13:0] len, input logic [5:0] st, input int nc,
                       input int d1, input int d2);
    phy_u.tx_frame(len, st, nc, d1, d2);
    if (st[4] || fbc_o) exp_c[7]++;
    if (d1 > lim || d2 > lim) exp_c[8]++;
    if (st[3]) exp_c[9]++;
    if (!st[5]) exp_c[10] += 32'(len);
    if (st[5] && nc == 1) exp_c[11]++;
    if (st[5] && nc > 1) exp_c[12]++;
    if (nc >= 16) exp_c[13]++;
    if (st[2]) exp_c[14]++;
    if (st[5] && st[1] && !st[0]) exp_c[15] += 32'(len);
    cmp_ctr(7, 15);
  endtask : tx_do
  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    close_out();
  end
  initial begin
    lim = 2 * int'(mstat_pkg::MAX_SIZE_RST) + int'(mstat_pkg::DEFER_MARGIN);
    do_reset();
    rdc(mstat_pkg::OFS_CTRL, 32'h0000_0000, "ctrl");
    rdc(mstat_pkg::OFS_MAX_SIZE, 32'(mstat_pkg::MAX_SIZE_RST), "max_size");
    rdc(8'h50, 32'h0000_0000, "unmapped");
    rdc(8'h11, 32'h0000_0000, "misaligned");
    bus(1'b1, mstat_pkg::OFS_CTR_BASE, 32'h0000_0005);
    foreach (rows[k]) begin
      bus(1'b1, mstat_pkg::OFS_CTRL, {29'h0, rows[k].fwd, 2'b00});
      phy_u.rx_frame(rows[k].len, rows[k].st);
      chk("fwd_pause", {31'h0, rows[k].fwd}, {31'h0, fwd_o});
      if (rows[k].bin != 4'h7) exp_c[rows[k].bin]++;
      cmp_ctr(0, 6);
    end
    bus(1'b1, mstat_pkg::OFS_CTRL, 32'h0000_0001);
    phy_u.lpi(45);
    phy_u.lpi(20);
    rdc(mstat_pkg::OFS_LPI_TRANS, 32'h0000_0002, "lpi_trans");
    rdc(mstat_pkg::OFS_LPI_TIME, 32'h0000_0003, "lpi_time");
    bus(1'b1, mstat_pkg::OFS_CTRL, 32'h0000_0000);
    phy_u.lpi(30);
    rdc(mstat_pkg::OFS_LPI_TRANS, 32'h0000_0000, "lpi_trans");
    rdc(mstat_pkg::OFS_LPI_TIME, 32'h0000_0000, "lpi_time");
    tx_do(14'h0064, 6'h22, 1, 0, 0);
    tx_do(14'h00c8, 6'h22, 3, 0, 0);
    tx_do(14'h012c, 6'h02, 16, 0, 0);
    chk("abort", 32'h0000_0001, 32'(abort_cnt));
    tx_do(14'h0046, 6'h06, 0, 0, 0);
    tx_do(14'h0050, 6'h0a, 0, 0, 0);
    bus(1'b1, mstat_pkg::OFS_CTRL, 32'h0000_0002);
    tx_do(14'h005a, 6'h02, 0, 0, 0);
    chk("force_bad", 32'h0000_0001, {31'h0, fbc_o});
    tx_do(14'h0040, 6'h23, 0, 0, 0);
    bus(1'b1, mstat_pkg::OFS_MAX_SIZE, 32'h0000_000a);
    rdc(mstat_pkg::OFS_MAX_SIZE, 32'h0000_000a, "max_size");
    lim = 2 * 10 + int'(mstat_pkg::DEFER_MARGIN);
    tx_do(14'h0040, 6'h20, 0, 40, 0);
    tx_do(14'h0040, 6'h20, 1, 30, 30);
    do_reset();
    rdc(mstat_pkg::OFS_CTR_BASE + 8'h2c, 32'h0000_0000, "ctr11_reset");
    rdc(mstat_pkg::OFS_MAX_SIZE, 32'(mstat_pkg::MAX_SIZE_RST), "max_size_reset");
    close_out();
  end
endmodule : testbench
`default_nettype wire
